// File: inc/ptq_pkg.sv
package ptq_pkg;

  // Widths
  localparam int CNT_W  = 16;
  localparam int DATA_W = 8;

  // Half-amplitude search
  localparam int HALF_AMPL_PCT = 50;
  localparam int MID_SHIFT     = 1;
  localparam int PEAK_WINDOW   = 4096;

  typedef enum logic [0:0] {
    PTQ_CLASS_RUNT  = 1'h0,
    PTQ_CLASS_WIDTH = 1'h1
  } ptq_class_t;

  typedef enum logic [1:0] {
    PTQ_RPOL_POS    = 2'h0,
    PTQ_RPOL_NEG    = 2'h1,
    PTQ_RPOL_EITHER = 2'h2
  } ptq_rpol_t;

  typedef enum logic [0:0] {
    PTQ_WPOL_POS = 1'h0,
    PTQ_WPOL_NEG = 1'h1
  } ptq_wpol_t;

  // Signal region relative to the two runt thresholds
  typedef enum logic [1:0] {
    PTQ_ZONE_LOW  = 2'h0,
    PTQ_ZONE_MID  = 2'h1,
    PTQ_ZONE_HIGH = 2'h3
  } ptq_zone_t;

  typedef enum logic [1:0] {
    PTQ_R_IDLE = 2'h0,
    PTQ_R_UP   = 2'h1,
    PTQ_R_DN   = 2'h3
  } ptq_rstate_t;

  typedef enum logic [1:0] {
    PTQ_W_IDLE = 2'h0,
    PTQ_W_ARM  = 2'h1,
    PTQ_W_MEAS = 2'h3
  } ptq_wstate_t;

  typedef enum logic [1:0] {
    PTQ_P_IDLE = 2'h0,
    PTQ_P_SCAN = 2'h1,
    PTQ_P_DONE = 2'h3
  } ptq_pstate_t;

  // Reset values and counter constants
  localparam logic [CNT_W-1:0]  LOWER_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  UPPER_RST  = 16'hffff;
  localparam logic [DATA_W-1:0] HIGH_RST   = 8'hc0;
  localparam logic [DATA_W-1:0] LOW_RST    = 8'h40;
  localparam logic [DATA_W-1:0] LEVEL_RST  = 8'h80;
  localparam logic [DATA_W-1:0] DATA_MIN   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_MAX   = 8'hff;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_SAT    = 16'hffff;

endpackage : ptq_pkg

// File: core/ptq_limit_order.sv
`timescale 1ns/100ps
module ptq_limit_order #(
  parameter int CNT_W = ptq_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Limit write
  input  wire logic             limitWrite,
  input  wire logic [CNT_W-1:0] lowerIn,
  input  wire logic [CNT_W-1:0] upperIn,
  // Ordered limits
  output logic      [CNT_W-1:0] lowerLimit,
  output logic      [CNT_W-1:0] upperLimit
);

  typedef struct packed {
    logic [CNT_W-1:0] lower;
    logic [CNT_W-1:0] upper;
  } ptq_lim_t;

  ptq_lim_t st_ff;
  ptq_lim_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (limitWrite) begin
      nxt_st.upper = upperIn;
      // Lower is pulled down to upper
      nxt_st.lower = (lowerIn > upperIn) ? upperIn : lowerIn;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff.lower <= CNT_W'(ptq_pkg::LOWER_RST);
      st_ff.upper <= CNT_W'(ptq_pkg::UPPER_RST);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lowerLimit = st_ff.lower;
  assign upperLimit = st_ff.upper;

endmodule : ptq_limit_order

// File: core/ptq_peak_mid.sv
`timescale 1ns/100ps
module ptq_peak_mid #(
  parameter int DATA_W = ptq_pkg::DATA_W,
  parameter int WINDOW = ptq_pkg::PEAK_WINDOW
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Search control
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] sample,
  // Result
  output logic      [DATA_W-1:0] midLevel,
  output logic                   busy,
  output logic                   done
);

  localparam int WIN_W = $clog2(WINDOW + 1);

  typedef struct packed {
    ptq_pkg::ptq_pstate_t state;
    logic [WIN_W-1:0]     cnt;
    logic [DATA_W-1:0]    maxV;
    logic [DATA_W-1:0]    minV;
    logic [DATA_W-1:0]    mid;
    logic                 done;
  } ptq_peak_t;

  ptq_peak_t st_ff;
  ptq_peak_t nxt_st;
  logic [DATA_W:0] peakSum;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    peakSum     = {1'b0, st_ff.maxV} + {1'b0, st_ff.minV};
    // Result first, so a restart in the same cycle keeps its full window
    if (st_ff.state == ptq_pkg::PTQ_P_DONE && st_ff.cnt == WIN_W'(0)) begin
      // Midway between peaks, computed once per search
      nxt_st.mid  = DATA_W'(peakSum >> ptq_pkg::MID_SHIFT);
      nxt_st.done = 1'b1;
      nxt_st.cnt  = WIN_W'(1);
    end
    case (st_ff.state)
      ptq_pkg::PTQ_P_IDLE, ptq_pkg::PTQ_P_DONE: begin
        if (start) begin
          nxt_st.state = ptq_pkg::PTQ_P_SCAN;
          nxt_st.cnt   = WIN_W'(WINDOW);
          nxt_st.maxV  = DATA_W'(ptq_pkg::DATA_MIN);
          nxt_st.minV  = DATA_W'(ptq_pkg::DATA_MAX);
        end
      end
      ptq_pkg::PTQ_P_SCAN: begin
        // Track both peaks over the window
        if (sample > st_ff.maxV) nxt_st.maxV = sample;
        if (sample < st_ff.minV) nxt_st.minV = sample;
        nxt_st.cnt = st_ff.cnt - WIN_W'(1);
        if (st_ff.cnt == WIN_W'(1)) begin
          nxt_st.state = ptq_pkg::PTQ_P_DONE;
        end
      end
      default: nxt_st.state = ptq_pkg::PTQ_P_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff.state <= ptq_pkg::PTQ_P_IDLE;
      st_ff.cnt   <= '0;
      st_ff.maxV  <= DATA_W'(ptq_pkg::DATA_MIN);
      st_ff.minV  <= DATA_W'(ptq_pkg::DATA_MAX);
      st_ff.mid   <= DATA_W'(ptq_pkg::LEVEL_RST);
      st_ff.done  <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign midLevel = st_ff.mid;
  assign busy     = (st_ff.state == ptq_pkg::PTQ_P_SCAN);
  assign done     = st_ff.done;

endmodule : ptq_peak_mid

// File: core/ptq_qualifier.sv
`timescale 1ns/100ps
module ptq_qualifier #(
  parameter int CNT_W       = ptq_pkg::CNT_W,
  parameter int DATA_W      = ptq_pkg::DATA_W,
  parameter int PEAK_WINDOW = ptq_pkg::PEAK_WINDOW
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Comparator indications, asynchronous
  input  wire logic                 aboveHighPin,
  input  wire logic                 aboveLowPin,
  input  wire logic                 aboveLevelPin,
  // Digitized trigger source
  input  wire logic [DATA_W-1:0]    sampleData,
  // Class and polarity
  input  wire ptq_pkg::ptq_class_t  classSel,
  input  wire ptq_pkg::ptq_rpol_t   runtPol,
  input  wire ptq_pkg::ptq_wpol_t   widthPol,
  input  wire logic                 outside_range_select,
  // Runt thresholds
  input  wire logic                 threshWrite,
  input  wire logic [DATA_W-1:0]    highThreshIn,
  input  wire logic [DATA_W-1:0]    lowThreshIn,
  // Width limits in clock cycles
  input  wire logic                 limitWrite,
  input  wire logic [CNT_W-1:0]     lowerLimitIn,
  input  wire logic [CNT_W-1:0]     upperLimitIn,
  // Trigger level
  input  wire logic                 levelHalfSelect,
  input  wire logic [DATA_W-1:0]    manualLevel,
  input  wire logic                 halfLevelStart,
  // Trigger event
  output logic                      trigEvent,
  // Comparator reference levels
  output logic      [DATA_W-1:0]    highThresh,
  output logic      [DATA_W-1:0]    lowThresh,
  output logic      [DATA_W-1:0]    trigLevel,
  // Status
  output logic      [CNT_W-1:0]     lowerLimit,
  output logic      [CNT_W-1:0]     upperLimit,
  output logic      [CNT_W-1:0]     lastWidth,
  output logic                      runtTracking,
  output logic                      widthMeasuring,
  output logic                      levelSearchBusy
);

  typedef struct packed {
    logic [2:0]           syncA;
    logic [2:0]           syncB;
    ptq_pkg::ptq_zone_t   zone;
    ptq_pkg::ptq_rstate_t rState;
    ptq_pkg::ptq_wstate_t wState;
    logic [CNT_W-1:0]     wCnt;
    logic [CNT_W-1:0]     width;
    logic [DATA_W-1:0]    high;
    logic [DATA_W-1:0]    low;
    logic [DATA_W-1:0]    level;
    ptq_pkg::ptq_class_t  prevClass;
    ptq_pkg::ptq_rpol_t   prevRpol;
    ptq_pkg::ptq_wpol_t   prevWpol;
    logic                 trig;
  } ptq_qual_t;

  ptq_qual_t st_ff;
  ptq_qual_t nxt_st;

  logic [DATA_W-1:0] midLevel;
  logic              searchBusy;
  logic              cfgChange;
  logic              runtHit;
  logic              widthHit;
  logic              srcActive;
  logic              isRunt;
  logic              posOk;
  logic              negOk;
  logic              inRange;
  ptq_pkg::ptq_zone_t zoneNow;

  // Region from the two synchronised comparator outputs
  function automatic ptq_pkg::ptq_zone_t zoneOf(input logic hi, input logic lo);
    if (hi) begin
      return ptq_pkg::PTQ_ZONE_HIGH;
    end else if (lo) begin
      return ptq_pkg::PTQ_ZONE_MID;
    end
    return ptq_pkg::PTQ_ZONE_LOW;
  endfunction : zoneOf

  // Width test against the ordered limits
  function automatic logic widthInRange(input logic [CNT_W-1:0] w,
                                        input logic [CNT_W-1:0] lo,
                                        input logic [CNT_W-1:0] hi);
    return (w >= lo) && (w <= hi);
  endfunction : widthInRange

  ptq_limit_order #(
    .CNT_W      (CNT_W)
  ) u_limits (
    .mclk       (mclk),
    .rst        (rst),
    .limitWrite (limitWrite),
    .lowerIn    (lowerLimitIn),
    .upperIn    (upperLimitIn),
    .lowerLimit (lowerLimit),
    .upperLimit (upperLimit)
  );

  ptq_peak_mid #(
    .DATA_W   (DATA_W),
    .WINDOW   (PEAK_WINDOW)
  ) u_peak (
    .mclk     (mclk),
    .rst      (rst),
    .start    (halfLevelStart),
    .sample   (sampleData),
    .midLevel (midLevel),
    .busy     (searchBusy),
    .done     ()
  );

  // Second sync stage only; first stage feeds nothing else
  assign zoneNow   = zoneOf(st_ff.syncB[0], st_ff.syncB[1]);
  assign srcActive = (widthPol == ptq_pkg::PTQ_WPOL_POS) ? st_ff.syncB[2]
                                                         : ~st_ff.syncB[2];
  assign isRunt    = (classSel == ptq_pkg::PTQ_CLASS_RUNT);
  assign posOk     = (runtPol == ptq_pkg::PTQ_RPOL_POS) ||
                     (runtPol == ptq_pkg::PTQ_RPOL_EITHER);
  assign negOk     = (runtPol == ptq_pkg::PTQ_RPOL_NEG) ||
                     (runtPol == ptq_pkg::PTQ_RPOL_EITHER);
  assign cfgChange = (classSel != st_ff.prevClass) ||
                     (runtPol != st_ff.prevRpol) ||
                     (widthPol != st_ff.prevWpol);
  assign inRange   = widthInRange(st_ff.wCnt, lowerLimit, upperLimit);

  always_comb begin
    nxt_st           = st_ff;
    runtHit          = 1'b0;
    widthHit         = 1'b0;
    nxt_st.syncA     = {aboveLevelPin, aboveLowPin, aboveHighPin};
    nxt_st.syncB     = st_ff.syncA;
    nxt_st.zone      = zoneNow;
    nxt_st.prevClass = classSel;
    nxt_st.prevRpol  = runtPol;
    nxt_st.prevWpol  = widthPol;

    if (threshWrite) begin
      nxt_st.high = highThreshIn;
      nxt_st.low  = lowThreshIn;
    end

    // Trigger level source
    nxt_st.level = levelHalfSelect ? midLevel : manualLevel;

    // Runt tracking on region changes
    case (st_ff.rState)
      ptq_pkg::PTQ_R_IDLE: begin
        if (st_ff.zone == ptq_pkg::PTQ_ZONE_LOW &&
            zoneNow == ptq_pkg::PTQ_ZONE_MID && posOk) begin
          nxt_st.rState = ptq_pkg::PTQ_R_UP;
        end else if (st_ff.zone == ptq_pkg::PTQ_ZONE_HIGH &&
                     zoneNow == ptq_pkg::PTQ_ZONE_MID && negOk) begin
          nxt_st.rState = ptq_pkg::PTQ_R_DN;
        end
      end
      ptq_pkg::PTQ_R_UP: begin
        if (zoneNow == ptq_pkg::PTQ_ZONE_LOW) begin
          runtHit       = 1'b1;
          nxt_st.rState = ptq_pkg::PTQ_R_IDLE;
        end else if (zoneNow == ptq_pkg::PTQ_ZONE_HIGH) begin
          // Full pulse reached the upper threshold
          nxt_st.rState = ptq_pkg::PTQ_R_IDLE;
        end
      end
      ptq_pkg::PTQ_R_DN: begin
        if (zoneNow == ptq_pkg::PTQ_ZONE_HIGH) begin
          runtHit       = 1'b1;
          nxt_st.rState = ptq_pkg::PTQ_R_IDLE;
        end else if (zoneNow == ptq_pkg::PTQ_ZONE_LOW) begin
          nxt_st.rState = ptq_pkg::PTQ_R_IDLE;
        end
      end
      default: nxt_st.rState = ptq_pkg::PTQ_R_IDLE;
    endcase

    // Width measurement; a pulse already under way is skipped
    case (st_ff.wState)
      ptq_pkg::PTQ_W_IDLE: begin
        if (!srcActive) begin
          nxt_st.wState = ptq_pkg::PTQ_W_ARM;
        end
      end
      ptq_pkg::PTQ_W_ARM: begin
        if (srcActive) begin
          nxt_st.wState = ptq_pkg::PTQ_W_MEAS;
          nxt_st.wCnt   = CNT_W'(ptq_pkg::CNT_ONE);
        end
      end
      ptq_pkg::PTQ_W_MEAS: begin
        if (srcActive) begin
          if (st_ff.wCnt != CNT_W'(ptq_pkg::CNT_SAT)) begin
            nxt_st.wCnt = st_ff.wCnt + CNT_W'(ptq_pkg::CNT_ONE);
          end
        end else begin
          nxt_st.width  = st_ff.wCnt;
          nxt_st.wState = ptq_pkg::PTQ_W_ARM;
          if (outside_range_select) begin
            widthHit = ~inRange;
          end else begin
            widthHit = inRange;
          end
        end
      end
      default: nxt_st.wState = ptq_pkg::PTQ_W_IDLE;
    endcase

    nxt_st.trig = isRunt ? runtHit : widthHit;

    // Setting change drops partial tracking
    if (cfgChange) begin
      nxt_st.rState = ptq_pkg::PTQ_R_IDLE;
      nxt_st.wState = ptq_pkg::PTQ_W_IDLE;
      nxt_st.wCnt   = CNT_W'(ptq_pkg::CNT_ZERO);
      nxt_st.trig   = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff.syncA     <= '0;
      st_ff.syncB     <= '0;
      st_ff.zone      <= ptq_pkg::PTQ_ZONE_LOW;
      st_ff.rState    <= ptq_pkg::PTQ_R_IDLE;
      st_ff.wState    <= ptq_pkg::PTQ_W_IDLE;
      st_ff.wCnt      <= CNT_W'(ptq_pkg::CNT_ZERO);
      st_ff.width     <= CNT_W'(ptq_pkg::CNT_ZERO);
      st_ff.high      <= DATA_W'(ptq_pkg::HIGH_RST);
      st_ff.low       <= DATA_W'(ptq_pkg::LOW_RST);
      st_ff.level     <= DATA_W'(ptq_pkg::LEVEL_RST);
      st_ff.prevClass <= ptq_pkg::PTQ_CLASS_RUNT;
      st_ff.prevRpol  <= ptq_pkg::PTQ_RPOL_POS;
      st_ff.prevWpol  <= ptq_pkg::PTQ_WPOL_POS;
      st_ff.trig      <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign trigEvent       = st_ff.trig;
  assign highThresh      = st_ff.high;
  assign lowThresh       = st_ff.low;
  assign trigLevel       = st_ff.level;
  assign lastWidth       = st_ff.width;
  assign runtTracking    = (st_ff.rState != ptq_pkg::PTQ_R_IDLE);
  assign widthMeasuring  = (st_ff.wState == ptq_pkg::PTQ_W_MEAS);
  assign levelSearchBusy = searchBusy;

endmodule : ptq_qualifier

// File: bench/ptq_comparator_model.sv
`timescale 1ns/100ps
module ptq_comparator_model (
  // Source level and references
  input  wire logic [7:0] srcLevel,
  input  wire logic [7:0] highThresh,
  input  wire logic [7:0] lowThresh,
  input  wire logic [7:0] trigLevel,
  // Comparator outputs
  output logic            aboveHighPin,
  output logic            aboveLowPin,
  output logic            aboveLevelPin
);
  assign aboveHighPin  = srcLevel > highThresh;
  assign aboveLowPin   = srcLevel > lowThresh;
  assign aboveLevelPin = srcLevel > trigLevel;
endmodule : ptq_comparator_model

// File: bench/ptq_qualifier_assertions.sv
`timescale 1ns/100ps
module ptq_qualifier_assertions #(
  parameter int PEAK_WINDOW = 8
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  // Settings
  input wire ptq_pkg::ptq_class_t classSel,
  input wire ptq_pkg::ptq_rpol_t  runtPol,
  input wire ptq_pkg::ptq_wpol_t  widthPol,
  input wire logic                outside_range_select,
  input wire logic                threshWrite,
  input wire logic [7:0]          highThreshIn,
  input wire logic [7:0]          lowThreshIn,
  input wire logic                limitWrite,
  input wire logic [15:0]         lowerLimitIn,
  input wire logic [15:0]         upperLimitIn,
  input wire logic                levelHalfSelect,
  input wire logic [7:0]          manualLevel,
  // Outputs
  input wire logic                trigEvent,
  input wire logic [7:0]          highThresh,
  input wire logic [7:0]          lowThresh,
  input wire logic [7:0]          trigLevel,
  input wire logic [15:0]         lowerLimit,
  input wire logic [15:0]         upperLimit,
  input wire logic [15:0]         lastWidth,
  input wire logic                runtTracking,
  input wire logic                levelSearchBusy
);
  int busyCnt;

  // Length of the current peak search in cycles
  always_ff @(posedge mclk) begin
    if (rst || !levelSearchBusy) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= busyCnt + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_TRIG_ONE: assert property (trigEvent |=> !trigEvent)
    else $error("trigger pulse longer than one cycle");
  AST_LIM_ORDER: assert property (lowerLimit <= upperLimit)
    else $error("lower limit above upper limit");
  AST_LIM_LOAD: assert property (limitWrite |=> upperLimit == $past(upperLimitIn) &&
    lowerLimit == (($past(lowerLimitIn) > $past(upperLimitIn)) ? $past(upperLimitIn) :
    $past(lowerLimitIn))) else $error("limit load wrong");
  AST_THR_LOAD: assert property (threshWrite |=> highThresh == $past(highThreshIn) &&
    lowThresh == $past(lowThreshIn)) else $error("threshold load wrong");
  AST_SET_CLEAR: assert property (($changed(classSel) || $changed(runtPol) ||
    $changed(widthPol)) |=> !runtTracking) else $error("tracking kept over setting change");
  AST_RUNT_RECROSS: assert property (trigEvent && $past(classSel) == ptq_pkg::PTQ_CLASS_RUNT
    |-> $past(runtTracking)) else $error("runt trigger without first crossing");
  AST_WIN_HIT: assert property (trigEvent && classSel == ptq_pkg::PTQ_CLASS_WIDTH &&
    !outside_range_select |-> lastWidth >= lowerLimit && lastWidth <= upperLimit)
    else $error("within trigger on width out of range");
  AST_OUT_HIT: assert property (trigEvent && classSel == ptq_pkg::PTQ_CLASS_WIDTH &&
    outside_range_select |-> lastWidth < lowerLimit || lastWidth > upperLimit)
    else $error("outside trigger on width in range");
  AST_LVL_MAN: assert property (!levelHalfSelect && !$past(levelHalfSelect) && !$past(rst)
    && $stable(manualLevel) |-> trigLevel == manualLevel) else $error("manual level lost");
  AST_SCAN_LEN: assert property ($fell(levelSearchBusy) |->
    busyCnt == PEAK_WINDOW) else $error("peak search length wrong");
endmodule : ptq_qualifier_assertions

bind ptq_qualifier ptq_qualifier_assertions #(.PEAK_WINDOW(PEAK_WINDOW)) i_ast (
  .mclk(mclk), .rst(rst), .classSel(classSel), .runtPol(runtPol), .widthPol(widthPol),
  .outside_range_select(outside_range_select), .threshWrite(threshWrite),
  .highThreshIn(highThreshIn), .lowThreshIn(lowThreshIn), .limitWrite(limitWrite),
  .lowerLimitIn(lowerLimitIn), .upperLimitIn(upperLimitIn), .levelHalfSelect(levelHalfSelect),
  .manualLevel(manualLevel), .trigEvent(trigEvent), .highThresh(highThresh),
  .lowThresh(lowThresh), .trigLevel(trigLevel), .lowerLimit(lowerLimit),
  .upperLimit(upperLimit), .lastWidth(lastWidth), .runtTracking(runtTracking),
  .levelSearchBusy(levelSearchBusy));

// File: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic                mclk = 1'b0;
  logic                rst  = 1'b1;
  logic [7:0]          srcLevel = 8'h20;
  logic [7:0]          sampleData = 8'h10;
  ptq_pkg::ptq_class_t classSel = ptq_pkg::PTQ_CLASS_RUNT;
  ptq_pkg::ptq_rpol_t  runtPol = ptq_pkg::PTQ_RPOL_POS;
  ptq_pkg::ptq_wpol_t  widthPol = ptq_pkg::PTQ_WPOL_POS;
  logic                outSel = 1'b0;
  logic                thrWr = 1'b0;
  logic                limWr = 1'b0;
  logic                halfSel = 1'b0;
  logic                halfGo = 1'b0;
  logic [7:0]          highIn = 8'ha0;
  logic [7:0]          lowIn = 8'h60;
  logic [7:0]          manLvl = 8'h80;
  logic [15:0]         lowerIn = 16'h0009;
  logic [15:0]         upperIn = 16'h0005;
  logic                aHigh, aLow, aLevel, trigEvent, runtTracking, measuring, busy;
  logic [7:0]          highThresh, lowThresh, trigLevel;
  logic [15:0]         lowerLimit, upperLimit, lastWidth;
  logic [31:0]         rng = 32'h000112d3;
  int                  fails = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  int                  trigs = 0;
  int                  arm = 0;
  int                  pz = 0;
  int                  seq [11] = '{0, 1, 0, 1, 2, 1, 2, 1, 0, 2, 0};

  always #12.5 mclk = ~mclk;

  ptq_comparator_model i_cmp (.srcLevel(srcLevel), .highThresh(highThresh),
    .lowThresh(lowThresh), .trigLevel(trigLevel), .aboveHighPin(aHigh),
    .aboveLowPin(aLow), .aboveLevelPin(aLevel));

  ptq_qualifier #(.PEAK_WINDOW(8)) i_dut (.mclk(mclk), .rst(rst), .aboveHighPin(aHigh),
    .aboveLowPin(aLow), .aboveLevelPin(aLevel), .sampleData(sampleData),
    .classSel(classSel), .runtPol(runtPol), .widthPol(widthPol),
    .outside_range_select(outSel), .threshWrite(thrWr), .highThreshIn(highIn),
    .lowThreshIn(lowIn), .limitWrite(limWr), .lowerLimitIn(lowerIn),
    .upperLimitIn(upperIn), .levelHalfSelect(halfSel), .manualLevel(manLvl),
    .halfLevelStart(halfGo), .trigEvent(trigEvent), .highThresh(highThresh),
    .lowThresh(lowThresh), .trigLevel(trigLevel), .lowerLimit(lowerLimit),
    .upperLimit(upperLimit), .lastWidth(lastWidth), .runtTracking(runtTracking),
    .widthMeasuring(measuring), .levelSearchBusy(busy));

  always @(posedge mclk) begin
    cycles++;
    if (trigEvent === 1'b1) trigs++;
    if (cycles == 4000) begin
      fails++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Move source into a zone and score the runt model
  task automatic zstep(input int z);
    int fire;
    fire = (arm == 1 && z == 0) || (arm == 2 && z == 2);
    if (z != 1) arm = 0;
    else if (pz == 0 && runtPol != ptq_pkg::PTQ_RPOL_NEG) arm = 1;
    else if (pz == 2 && runtPol != ptq_pkg::PTQ_RPOL_POS) arm = 2;
    pz = z;
    trigs = 0;
    srcLevel = (z == 0) ? 8'h20 : (z == 1) ? 8'h80 : 8'he0;
    cyc(8);
    check(trigs, fire, "runt trigger count");
    check(runtTracking, arm != 0, "runt tracking");
  endtask : zstep

  task automatic pulse(input int w);
    logic act;
    int   want;
    act = (widthPol == ptq_pkg::PTQ_WPOL_POS);
    want = outSel ? (w < lowerIn || w > upperIn) : (w >= lowerIn && w <= upperIn);
    trigs = 0;
    srcLevel = act ? 8'he0 : 8'h20;
    cyc(w);
    // Two sync stages plus arming delay the start by three cycles
    check(measuring, w >= 3, "measuring");
    srcLevel = act ? 8'h20 : 8'he0;
    cyc(10);
    check(trigs, want, "width trigger");
    check(lastWidth, w, "measured width");
    check(measuring, 1'b0, "measure ended");
  endtask : pulse

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(4);
    check({highThresh, lowThresh, trigLevel}, 24'hc04080, "reset levels");
    check({lowerLimit, upperLimit}, 32'h0000ffff, "reset limits");
    thrWr = 1'b1;
    limWr = 1'b1;
    cyc(1);
    thrWr = 1'b0;
    limWr = 1'b0;
    check({highThresh, lowThresh}, 16'ha060, "threshold load");
    check({lowerLimit, upperLimit}, 32'h00050005, "limit ordering");
    lowerIn = 16'h0003;
    limWr = 1'b1;
    cyc(1);
    limWr = 1'b0;
    check({lowerLimit, upperLimit}, 32'h00030005, "limit load");
    $display("test config done");
    for (int p = 0; p < 3; p++) begin
      runtPol = ptq_pkg::ptq_rpol_t'(p);
      arm = 0;
      cyc(2);
      foreach (seq[i]) zstep(seq[i]);
      for (int i = 0; i < 20; i++) begin
        rng = xs(rng);
        zstep(rng % 3);
      end
    end
    runtPol = ptq_pkg::PTQ_RPOL_POS;
    arm = 0;
    zstep(0);
    zstep(1);
    runtPol = ptq_pkg::PTQ_RPOL_EITHER;
    cyc(1);
    runtPol = ptq_pkg::PTQ_RPOL_POS;
    arm = 0;
    zstep(0);
    $display("test runt done");
    classSel = ptq_pkg::PTQ_CLASS_WIDTH;
    for (int m = 0; m < 4; m++) begin
      widthPol = ptq_pkg::ptq_wpol_t'(m / 2);
      outSel = m[0];
      srcLevel = (m < 2) ? 8'h20 : 8'he0;
      cyc(10);
      foreach (seq[i]) pulse(i < 5 ? seq[i] * 2 + 3 - (i % 2) : 1 + (xs(rng + i) % 8));
    end
    $display("test width done");
    halfSel = 1'b1;
    halfGo = 1'b1;
    cyc(1);
    halfGo = 1'b0;
    cyc(2);
    check(busy, 1'b1, "search busy");
    sampleData = 8'hd0;
    cyc(3);
    sampleData = 8'h10;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) cyc(1);
    cyc(4);
    check(trigLevel, 8'h70, "half amplitude level");
    rng = xs(rng);
    manLvl = {rng[7:1], 1'b1};
    halfSel = 1'b0;
    cyc(3);
    check(trigLevel, manLvl, "manual level");
    $display("test level done");
    stop_test();
  end
endmodule : tb_top
